// ### csf_consts.svh
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// Number of differential output pairs
`define CSF_NUM_OUT        9
// Levels assumed for pins left open
`define CSF_TRUE_OPEN_LVL  1'b0
`define CSF_COMP_OPEN_LVL  1'b1
`define CSF_SEL_OPEN_LVL   1'b1
`define CSF_OE_OPEN_LVL    1'b1
// Reset values of the gate logic
`define CSF_SMP_RST        1'b0
`define CSF_LVL_RST        1'b0
`define CSF_OUT_TRUE_RST   1'b0

`endif

// ### csf_pkg.sv
`default_nettype none

package csf_pkg;

  // Output gate state, one-hot
  typedef enum logic [1:0] {
    CSF_GATE_OFF = 2'b01,
    CSF_GATE_ON  = 2'b10
  } csf_gate_t;

  // Resolves a pin that may be left open to its default level
  function automatic logic csf_pin(input logic val, input logic open, input logic dflt);
    return open ? dflt : val;
  endfunction

endpackage

`default_nettype wire

// ### csf_diff_rx.sv
`include "csf_consts.svh"
`default_nettype none

module csf_diff_rx
  import csf_pkg::*;
(
  input  wire logic true_i,
  input  wire logic true_open_i,
  input  wire logic comp_i,
  input  wire logic comp_open_i,
  output logic      level_o
);

  logic true_eff;
  logic comp_eff;

  // Open legs take their default; a fully open pair reads as a static low
  always_comb begin
    true_eff = csf_pin(true_i, true_open_i, `CSF_TRUE_OPEN_LVL);
    comp_eff = csf_pin(comp_i, comp_open_i, `CSF_COMP_OPEN_LVL);
    level_o  = true_eff & ~comp_eff;
  end

endmodule

`default_nettype wire

// ### csf_clock_fanout.sv
// Behaviour
// - Nine differential pairs all carry the same selected clock, complement inverted.
// - Select low routes the HSTL clock, select high routes the PECL clock.
// - Gate low holds true legs low and complement legs high.
// - Enable state changes only while the clock is low; the gate causes no runt pulses.
// - Output gate is sampled on the rising input clock edge, not combinationally.
// - Open select, open gate and open complement legs read as high.
// - Open true legs read as low; a fully open pair is a static low.
// - Gate sampled low keeps outputs disabled for the following clock cycle.
// - Gate sampled high passes the next input clock period normally.
`include "csf_consts.svh"
`default_nettype none

module csf_clock_fanout
  import csf_pkg::*;
#(
  parameter int NUM_OUT = `CSF_NUM_OUT
) (
  input  wire logic               mclk_i,
  input  wire logic               arst_n_i,
  input  wire logic               hstl_clock_in_true_i,
  input  wire logic               hstl_clock_in_true_open_i,
  input  wire logic               hstl_clock_in_comp_i,
  input  wire logic               hstl_clock_in_comp_open_i,
  input  wire logic               pecl_clock_in_true_i,
  input  wire logic               pecl_clock_in_true_open_i,
  input  wire logic               pecl_clock_in_comp_i,
  input  wire logic               pecl_clock_in_comp_open_i,
  input  wire logic               src_sel_i,
  input  wire logic               src_sel_open_i,
  input  wire logic               out_gate_i,
  input  wire logic               out_gate_open_i,
  output logic [NUM_OUT-1:0]      fanout_outputs_true_o,
  output logic [NUM_OUT-1:0]      fanout_outputs_comp_o
);

  logic              hstl_lvl;
  logic              pecl_lvl;
  logic              sel_eff;
  logic              gate_eff;
  logic              sel_lvl;
  logic              rise;
  logic              lvl_q;
  logic              lvl_d;
  logic              smp_q;
  logic              smp_d;
  csf_gate_t         state_q;
  csf_gate_t         state_d;
  logic [NUM_OUT-1:0] true_q;
  logic [NUM_OUT-1:0] true_d;

  // Differential receivers with open-pin defaults
  csf_diff_rx u_hstl_rx (
    .true_i      (hstl_clock_in_true_i),
    .true_open_i (hstl_clock_in_true_open_i),
    .comp_i      (hstl_clock_in_comp_i),
    .comp_open_i (hstl_clock_in_comp_open_i),
    .level_o     (hstl_lvl)
  );

  csf_diff_rx u_pecl_rx (
    .true_i      (pecl_clock_in_true_i),
    .true_open_i (pecl_clock_in_true_open_i),
    .comp_i      (pecl_clock_in_comp_i),
    .comp_open_i (pecl_clock_in_comp_open_i),
    .level_o     (pecl_lvl)
  );

  // Control pins and source multiplexer; the select has no glitch guard,
  // so switching it while the chosen clock is high can cut a pulse short
  always_comb begin
    sel_eff  = csf_pin(src_sel_i, src_sel_open_i, `CSF_SEL_OPEN_LVL);
    gate_eff = csf_pin(out_gate_i, out_gate_open_i, `CSF_OE_OPEN_LVL);
    sel_lvl  = sel_eff ? pecl_lvl : hstl_lvl;
    rise     = sel_lvl & ~lvl_q;
  end

  // Next state of the gate: sample on rising edge, apply while low.
  // Applying the sample only in a low phase is what keeps the gate from cutting any pulse short.
  always_comb begin
    lvl_d   = sel_lvl;
    smp_d   = smp_q;
    state_d = state_q;
    if (rise) begin
      smp_d = gate_eff;
    end
    if (!sel_lvl) begin
      state_d = smp_q ? CSF_GATE_ON : CSF_GATE_OFF;
    end
    true_d = (state_q == CSF_GATE_ON && sel_lvl) ? {NUM_OUT{1'b1}}
                                                 : {NUM_OUT{1'b0}};
  end

  // Gate registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvl_q   <= `CSF_LVL_RST;
      smp_q   <= `CSF_SMP_RST;
      state_q <= CSF_GATE_OFF;
      true_q  <= {NUM_OUT{`CSF_OUT_TRUE_RST}};
    end else begin
      lvl_q   <= lvl_d;
      smp_q   <= smp_d;
      state_q <= state_d;
      true_q  <= true_d;
    end
  end

  // Fan out one registered value to every pair
  assign fanout_outputs_true_o = true_q;
  assign fanout_outputs_comp_o = ~true_q;

  // Checks run on the system clock and rest while reset is held
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // Rising edges of the selected level, split by the enable sampled before them
  sequence s_rise_high;
    rise && smp_q;
  endsequence

  sequence s_rise_low;
    rise && !smp_q;
  endsequence

  // Every pair carries the same level, complement inverted
  property p_fanout_same;
    (fanout_outputs_true_o == {NUM_OUT{fanout_outputs_true_o[0]}})
      && (fanout_outputs_comp_o == ~fanout_outputs_true_o);
  endproperty
  a_fanout_same: assert property (p_fanout_same)
    else $error("Output pairs differ");

  // A high output needs the selected level high one cycle before
  property p_route;
    fanout_outputs_true_o[0] |-> $past(sel_eff ? pecl_lvl : hstl_lvl);
  endproperty
  a_route: assert property (p_route)
    else $error("High output without selected clock high");

  // Gate off forces true legs low and complement legs high
  property p_gate_off_low;
    (state_q == CSF_GATE_OFF) |=> (fanout_outputs_true_o == '0)
      && (fanout_outputs_comp_o == '1);
  endproperty
  a_gate_off_low: assert property (p_gate_off_low)
    else $error("Output active while gate off");

  property p_change_when_low;
    (state_q != $past(state_q)) |-> !$past(sel_lvl);
  endproperty
  a_change_when_low: assert property (p_change_when_low)
    else $error("Gate state changed while clock high");

  property p_sample_on_rise;
    (smp_q != $past(smp_q)) |-> $past(rise) && (smp_q == $past(gate_eff));
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise)
    else $error("Gate sample changed off a rising edge");

  property p_open_defaults;
    (src_sel_open_i |-> sel_eff) and (out_gate_open_i |-> gate_eff);
  endproperty
  a_open_defaults: assert property (p_open_defaults)
    else $error("Open control pin not read high");

  property p_open_pair_low;
    (hstl_clock_in_true_open_i && hstl_clock_in_comp_open_i |-> !hstl_lvl)
      and (pecl_clock_in_true_open_i && pecl_clock_in_comp_open_i |-> !pecl_lvl);
  endproperty
  a_open_pair_low: assert property (p_open_pair_low)
    else $error("Open clock pair not static low");

  property p_disabled_next;
    s_rise_low |-> (state_q == CSF_GATE_OFF) ##1 (fanout_outputs_true_o == '0);
  endproperty
  a_disabled_next: assert property (p_disabled_next)
    else $error("Clock passed after gate sampled low");

  property p_enabled_next;
    s_rise_high |-> (state_q == CSF_GATE_ON) ##1 (fanout_outputs_true_o == '1);
  endproperty
  a_enabled_next: assert property (p_enabled_next)
    else $error("Clock blocked after gate sampled high");

  property p_sampler_follows_sel;
    (smp_q != $past(smp_q)) |-> $past(sel_eff ? pecl_lvl : hstl_lvl) && !$past(lvl_q);
  endproperty
  a_sampler_follows_sel: assert property (p_sampler_follows_sel)
    else $error("Gate sampled off the unselected clock");

  // A pulse may only begin on a rising edge of the selected level
  property p_no_runt_start;
    $rose(fanout_outputs_true_o[0]) |-> $past(rise);
  endproperty
  a_no_runt_start: assert property (p_no_runt_start)
    else $error("Output pulse began off a rising edge");

  // A pulse may only end while the selected level is low
  property p_no_runt_end;
    $fell(fanout_outputs_true_o[0]) |-> !$past(sel_lvl);
  endproperty
  a_no_runt_end: assert property (p_no_runt_end)
    else $error("Output pulse cut while clock high");

  // While enabled the outputs copy the selected level one cycle later
  property p_follow_when_on;
    (state_q == CSF_GATE_ON) |=> (fanout_outputs_true_o[0] == $past(sel_lvl));
  endproperty
  a_follow_when_on: assert property (p_follow_when_on)
    else $error("Enabled output does not follow selected clock");

  // An open complement leg reads high, so its pair reads as a static low
  property p_open_comp_low;
    (hstl_clock_in_comp_open_i |-> !hstl_lvl) and (pecl_clock_in_comp_open_i |-> !pecl_lvl);
  endproperty
  a_open_comp_low: assert property (p_open_comp_low)
    else $error("Open complement leg not read high");

endmodule

`default_nettype wire

// ### csf_src_model.sv
`default_nettype none

module csf_src_model #(
  parameter int HI  = 1,
  parameter int PER = 2
) (
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  output logic      true_o,
  output logic      comp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // Free-running source clock
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_q <= 0;
    else cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
  end
  // Complement leg opposite
  assign true_o = cnt_q < HI;
  assign comp_o = !true_o;
endmodule

`default_nettype wire

// ### csf_clock_fanout_test.sv
`default_nettype none

module csf_clock_fanout_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, arst_n_i, ht, hc, pt, pc, sel, so, g, go, hto, hco, pto, pco;
  logic [8:0] q_t, q_c;
  int n_errors, compares;
  // Rows: select, select open, gate, gate open, HSTL true and comp open,
  // PECL true and comp open, then the count of highs in 24 cycles
  logic [12:0] rows [9] = '{13'h040c, 13'h1404, 13'h0000, 13'h1000, 13'h0a04, 13'h0500,
                            13'h1420, 13'h0580, 13'h1460};
  // Gate before each edge of the phased test, and the output level expected after it
  localparam logic [19:0] GATE_SEQ = 20'hff906;
  localparam logic [19:0] EXP_SEQ  = 20'h98019;

  // Sources: HSTL high 2 of 4, PECL high 1 of 6
  csf_src_model #(.HI(2), .PER(4)) i_hsrc (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .true_o(ht), .comp_o(hc));
  csf_src_model #(.HI(1), .PER(6)) i_psrc (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .true_o(pt), .comp_o(pc));

  csf_clock_fanout i_csf_clock_fanout (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .hstl_clock_in_true_i(ht), .hstl_clock_in_true_open_i(hto),
    .hstl_clock_in_comp_i(hc), .hstl_clock_in_comp_open_i(hco),
    .pecl_clock_in_true_i(pt), .pecl_clock_in_true_open_i(pto),
    .pecl_clock_in_comp_i(pc), .pecl_clock_in_comp_open_i(pco),
    .src_sel_i(sel), .src_sel_open_i(so), .out_gate_i(g), .out_gate_open_i(go),
    .fanout_outputs_true_o(q_t), .fanout_outputs_comp_o(q_c));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watches 24 cycles: leg pairing, whole pulses, count of highs
  task automatic watch(input int hi, input logic [8:0] exp_cnt, input bit use_cnt);
    int   run;
    int   cnt;
    logic prev;
    run = -99;
    cnt = 0;
    prev = q_t[0];
    repeat (24) begin
      @(negedge mclk_i);
      chk("comp legs", ~q_t, q_c);
      chk("true legs", {9{q_t[0]}}, q_t);
      if (q_t[0] === 1'b1) begin
        run++;
        cnt++;
      end else begin
        if (prev === 1'b1 && run > 0) chk("pulse width", 9'(hi), 9'(run));
        run = 0;
      end
      prev = q_t[0];
    end
    if (use_cnt) chk("high count", exp_cnt, 9'(cnt));
  endtask

  initial begin
    {sel, so, g, go, hto, hco, pto, pco} = '0;
    arst_n_i = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(negedge mclk_i);
    chk("reset true", 9'h000, q_t);
    chk("reset comp", 9'h1ff, q_c);
    arst_n_i = 1'b1;
    foreach (rows[i]) begin
      {sel, so, g, go, hto, hco, pto, pco} = rows[i][12:5];
      repeat (24) @(negedge mclk_i);
      watch((sel | so) ? 1 : 2, 9'(rows[i][4:0]), 1'b1);
    end
    // Gate toggled out of phase with the running HSTL clock
    {sel, so, g, go, hto, hco, pto, pco} = '0;
    fork
      repeat (8) begin
        repeat (3) @(negedge mclk_i);
        g = ~g;
      end
      watch(2, 9'h000, 1'b0);
    join
    // Gate stepped edge by edge from just after a rising edge of the HSTL clock
    g = 1'b1;
    repeat (12) @(negedge mclk_i);
    while (q_t[0] !== 1'b0) @(negedge mclk_i);
    while (q_t[0] !== 1'b1) @(negedge mclk_i);
    for (int k = 0; k < 20; k++) begin
      g = GATE_SEQ[k];
      @(negedge mclk_i);
      chk("phased gate", {9{EXP_SEQ[k]}}, q_t);
    end
    // Reset again in mid-run, then the first pulse after its release
    g = 1'b1;
    repeat (7) @(negedge mclk_i);
    arst_n_i = 1'b0;
    @(negedge mclk_i);
    chk("mid reset true", 9'h000, q_t);
    chk("mid reset comp", 9'h1ff, q_c);
    arst_n_i = 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(negedge mclk_i);
      chk("after reset", {9{k == 4}}, q_t);
    end
    test_done();
  end

  // Watchdog well past the expected run length
  initial begin
    #10000;
    n_errors++;
    test_done();
  end
endmodule

`default_nettype wire
